/* cbl_pkg.sv */
// Shared constants and carrier types of the condition-bit logic and leading-zero unit
`default_nettype none

package cbl_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int CBL_XLEN    = 32;
   localparam int CBL_ADDR_W  = 8;
   localparam int CBL_CLZ_W   = 6;

   // ************************************************************
   // Instruction field positions (bit 31 of the word is the MSB)
   // ************************************************************
   localparam int CBL_OPC_HI  = 31;
   localparam int CBL_OPC_LO  = 26;
   localparam int CBL_XO_HI   = 10;
   localparam int CBL_XO_LO   = 1;
   localparam int CBL_REC_POS = 0;
   localparam int CBL_D_HI    = 25;
   localparam int CBL_D_LO    = 21;
   localparam int CBL_A_HI    = 20;
   localparam int CBL_A_LO    = 16;
   localparam int CBL_B_HI    = 15;
   localparam int CBL_B_LO    = 11;
   localparam int CBL_CRF_HI  = 25;
   localparam int CBL_CRF_LO  = 23;
   localparam int CBL_LEN_POS = 21;
   localparam int CBL_IMM_HI  = 15;
   localparam int CBL_IMM_LO  = 0;

   // ************************************************************
   // Opcodes
   // ************************************************************
   localparam logic [5:0] CBL_OPC_X31   = 6'h1F;
   localparam logic [5:0] CBL_OPC_X19   = 6'h13;
   localparam logic [9:0] CBL_XO_CLZ    = 10'h01A;
   localparam logic [9:0] CBL_XO_ANDC   = 10'h081;
   localparam logic [9:0] CBL_XO_NOR    = 10'h021;

   // ************************************************************
   // Compare encodings and flag values
   // ************************************************************
   localparam logic [2:0] CBL_CMP_LESS  = 3'h4;
   localparam logic [2:0] CBL_CMP_GREAT = 3'h2;
   localparam logic [2:0] CBL_CMP_EQUAL = 3'h1;
   localparam logic [15:0] CBL_IMM_EXT  = 16'h0000;
   localparam logic [2:0] CBL_FIRST_FLD = 3'h0;

   // ************************************************************
   // Register offsets and reset values
   // ************************************************************
   localparam logic [7:0]  CBL_OFS_CTRL   = 8'h00;
   localparam logic [7:0]  CBL_OFS_CR     = 8'h04;
   localparam logic [7:0]  CBL_OFS_RESULT = 8'h08;
   localparam logic [7:0]  CBL_OFS_STATUS = 8'h0C;
   localparam logic [7:0]  CBL_OFS_COUNT  = 8'h10;
   localparam int          CBL_CTRL_EN    = 0;
   localparam int          CBL_STAT_BAD   = 0;
   localparam logic        CBL_CTRL_RST   = 1'h1;
   localparam logic [31:0] CBL_CR_RST     = 32'h0000_0000;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic        valid;
      logic [31:0] word;
      logic [31:0] operand;
      logic        sum_ovf;
   } cbl_issue_t;

   typedef struct packed {
      logic        wr_en;
      logic [4:0]  idx;
      logic [31:0] data;
   } cbl_gpr_wr_t;

endpackage

`default_nettype wire

/* cbl_unit.sv */
// Condition-bit logic, leading-zero count and unsigned compare-immediate datapath slice
`default_nettype none

// What this block does
// - Count zero bits from the MSB of the source; all zeros gives 32.
// - Leading-zero count decodes as opcode 0x1F, extended 0x1A; bit 0 records.
// - Recorded count updates first field from result and overflow, less-than forced zero.
// - AND writes first and second selected bits ANDed into destination bit.
// - AND-with-complement, extended 0x81, writes first AND NOT second.
// - Equivalence writes inverted XOR of both selected bits.
// - NAND writes inverted AND of both selected bits.
// - NOR writes inverted OR; decoded by opcode 0x13 with extended 0x21.
// - OR writes the plain OR of both selected bits.
// - OR-with-complement writes first OR NOT second.
// - XOR writes the plain XOR of both selected bits.
// - Bit operations change only the destination bit; all others hold.
// - Equivalence on one index sets it; XOR on one index clears it.
// - NOR with equal sources inverts; OR with equal sources copies.
// - Compare-immediate uses length zero; field zero unless another is named.
// - Compare source unsigned against immediate with sixteen zero bits above.
// - Field gets 100 less, 010 greater, 001 equal, then overflow copy.
// - Length operand one is an invalid form on this 32-bit core.
module cbl_unit
   import cbl_pkg::*;
#(
   parameter logic [5:0] OPC_CMPLI = 6'h0A,
   parameter logic [9:0] XO_AND    = 10'h101,
   parameter logic [9:0] XO_EQV    = 10'h121,
   parameter logic [9:0] XO_NAND   = 10'h0E1,
   parameter logic [9:0] XO_OR     = 10'h1C1,
   parameter logic [9:0] XO_ORC    = 10'h1A1,
   parameter logic [9:0] XO_XOR    = 10'h0C1,
   parameter int         COUNT_W   = 16
)(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire cbl_issue_t              issue,
   input  wire logic [CBL_ADDR_W-1:0]   bus_addr,
   input  wire logic [31:0]             bus_wdata,
   input  wire logic                    bus_wr,
   input  wire logic                    bus_rd,
   output logic      [31:0]             bus_rdata,
   output cbl_gpr_wr_t                  gpr_wr,
   output logic      [31:0]             cond_reg,
   output logic                         claimed,
   output logic                         invalid_form
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (COUNT_W < 1 || COUNT_W > 32)
      $error("COUNT_W must lie between 1 and 32");
   if (XO_AND == XO_EQV || XO_AND == XO_NAND || XO_AND == XO_OR || XO_AND == XO_ORC ||
       XO_AND == XO_XOR || XO_EQV == XO_NAND || XO_EQV == XO_OR || XO_EQV == XO_ORC ||
       XO_EQV == XO_XOR || XO_NAND == XO_OR || XO_NAND == XO_ORC || XO_NAND == XO_XOR ||
       XO_OR == XO_ORC || XO_OR == XO_XOR || XO_ORC == XO_XOR)
      $error("Bit-logic extended opcodes must all differ");

   // ************************************************************
   // Declarations
   // ************************************************************
   logic                 enable;
   logic                 bad_sticky;
   logic [31:0]          last_result;
   logic [COUNT_W-1:0]   exec_count;
   logic [5:0]           opc;
   logic [9:0]           xo;
   logic                 rec;
   logic [4:0]           idx_d;
   logic [4:0]           idx_a;
   logic [4:0]           idx_b;
   logic [2:0]           crf;
   logic                 len_op;
   logic [15:0]          unsigned_immediate;
   logic                 is_clz;
   logic                 is_crl;
   logic                 is_cmp;
   logic                 cmp_bad;
   logic                 cmp_ok;
   logic                 clz_rec;
   logic                 src_a;
   logic                 src_b;
   logic                 crl_bit;
   logic [CBL_CLZ_W-1:0] clz_n;
   logic [31:0]          imm_ext;
   logic [3:0]           clz_field;
   logic [3:0]           cmp_field;
   logic [2:0]           cmp_code;
   logic                 cr_bus_wr;
   logic [31:0]          next_cr;
   logic [31:0]          next_rdata;

   // ************************************************************
   // Instruction field extraction
   // ************************************************************
   // Fields sliced from the issued word
   assign opc    = issue.word[CBL_OPC_HI:CBL_OPC_LO];
   assign xo     = issue.word[CBL_XO_HI:CBL_XO_LO];
   assign rec    = issue.word[CBL_REC_POS];
   assign idx_d  = issue.word[CBL_D_HI:CBL_D_LO];
   assign idx_a  = issue.word[CBL_A_HI:CBL_A_LO];
   assign idx_b  = issue.word[CBL_B_HI:CBL_B_LO];
   assign crf    = issue.word[CBL_CRF_HI:CBL_CRF_LO];
   assign len_op = issue.word[CBL_LEN_POS];
   assign unsigned_immediate   = issue.word[CBL_IMM_HI:CBL_IMM_LO];

   // ************************************************************
   // Decode
   // ************************************************************
   // Recognise the three instruction groups while enabled
   assign is_clz  = issue.valid && enable && opc == CBL_OPC_X31 && xo == CBL_XO_CLZ;
   assign is_crl  = issue.valid && enable && opc == CBL_OPC_X19 &&
                    (xo == XO_AND || xo == CBL_XO_ANDC || xo == XO_EQV || xo == XO_NAND ||
                     xo == CBL_XO_NOR || xo == XO_OR || xo == XO_ORC || xo == XO_XOR);
   assign is_cmp  = issue.valid && enable && opc == OPC_CMPLI;
   assign cmp_bad = is_cmp && len_op;
   assign cmp_ok  = is_cmp && !len_op;
   assign clz_rec = is_clz && rec;

   // ************************************************************
   // Leading-zero count
   // ************************************************************
   // Highest set bit wins; no set bit leaves the full width
   always_comb
   begin
      clz_n = 6'(CBL_XLEN);
      for (int i = 0; i < CBL_XLEN; i++)
      begin
         if (issue.operand[i])
            clz_n = 6'(CBL_XLEN - 1 - i);
      end
   end

   // Recorded field: less-than held low, zero test of the count
   assign clz_field = {1'b0, clz_n != '0, clz_n == '0, issue.sum_ovf};

   // ************************************************************
   // Unsigned compare against zero-extended immediate
   // ************************************************************
   assign imm_ext = {CBL_IMM_EXT, unsigned_immediate};

   // Three-way unsigned result code
   always_comb
   begin
      if (issue.operand < imm_ext)
         cmp_code = CBL_CMP_LESS;
      else if (issue.operand > imm_ext)
         cmp_code = CBL_CMP_GREAT;
      else
         cmp_code = CBL_CMP_EQUAL;
   end

   assign cmp_field = {cmp_code, issue.sum_ovf};

   // ************************************************************
   // Condition-bit logic
   // ************************************************************
   // Source bits, index 0 being the MSB
   assign src_a = cond_reg[5'(CBL_XLEN - 1) - idx_a];
   assign src_b = cond_reg[5'(CBL_XLEN - 1) - idx_b];

   // One result bit per bit-logic opcode
   always_comb
   begin
      crl_bit = 1'b0;
      if (xo == XO_AND)
         crl_bit = src_a & src_b;
      else if (xo == CBL_XO_ANDC)
         crl_bit = src_a & ~src_b;
      else if (xo == XO_EQV)
         crl_bit = ~(src_a ^ src_b);
      else if (xo == XO_NAND)
         crl_bit = ~(src_a & src_b);
      else if (xo == CBL_XO_NOR)
         crl_bit = ~(src_a | src_b);
      else if (xo == XO_OR)
         crl_bit = src_a | src_b;
      else if (xo == XO_ORC)
         crl_bit = src_a | ~src_b;
      else if (xo == XO_XOR)
         crl_bit = src_a ^ src_b;
   end

   // ************************************************************
   // Next condition register, one bit at a time
   // ************************************************************
   assign cr_bus_wr = bus_wr && bus_addr == CBL_OFS_CR;

   // Bus write first, then the instruction's own bit or field on top
   for (genvar i = 0; i < CBL_XLEN; i++)
   begin : g_cr_bit
      localparam int BIDX = CBL_XLEN - 1 - i;
      localparam int FLD  = BIDX / 4;
      logic base;
      assign base = cr_bus_wr ? bus_wdata[i] : cond_reg[i];
      always_comb
      begin
         if (is_crl && idx_d == 5'(BIDX))
            next_cr[i] = crl_bit;
         else if (clz_rec && FLD == 0)
            next_cr[i] = clz_field[i % 4];
         else if (cmp_ok && crf == 3'(FLD))
            next_cr[i] = cmp_field[i % 4];
         else
            next_cr[i] = base;
      end
   end

   // Condition register storage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cond_reg <= CBL_CR_RST;
      else
         cond_reg <= next_cr;
   end

   // ************************************************************
   // General register write-back
   // ************************************************************
   // Count result goes to the destination register one cycle on
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gpr_wr <= '0;
      end
      else
      begin
         gpr_wr.wr_en <= is_clz;
         gpr_wr.idx   <= idx_a;
         gpr_wr.data  <= 32'(clz_n);
      end
   end

   // ************************************************************
   // Issue status pulses
   // ************************************************************
   // Accepted and refused instruction pulses
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         claimed      <= 1'b0;
         invalid_form <= 1'b0;
      end
      else
      begin
         claimed      <= is_clz || is_crl || cmp_ok;
         invalid_form <= cmp_bad;
      end
   end

   // ************************************************************
   // Software registers
   // ************************************************************
   // Enable control
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         enable <= CBL_CTRL_RST;
      else if (bus_wr && bus_addr == CBL_OFS_CTRL)
         enable <= bus_wdata[CBL_CTRL_EN];
   end

   // Invalid-form sticky flag; a new event beats a clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         bad_sticky <= 1'b0;
      else if (cmp_bad)
         bad_sticky <= 1'b1;
      else if (bus_wr && bus_addr == CBL_OFS_STATUS && bus_wdata[CBL_STAT_BAD])
         bad_sticky <= 1'b0;
   end

   // Last leading-zero count
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         last_result <= '0;
      else if (is_clz)
         last_result <= 32'(clz_n);
   end

   // Executed instruction counter, wraps
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         exec_count <= '0;
      else if (is_clz || is_crl || cmp_ok)
         exec_count <= exec_count + COUNT_W'(1);
   end

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      next_rdata = '0;
      if (bus_rd)
      begin
         unique case (bus_addr)
            CBL_OFS_CTRL:   next_rdata = 32'(enable);
            CBL_OFS_CR:     next_rdata = cond_reg;
            CBL_OFS_RESULT: next_rdata = last_result;
            CBL_OFS_STATUS: next_rdata = 32'(bad_sticky);
            CBL_OFS_COUNT:  next_rdata = 32'(exec_count);
            default:        next_rdata = '0;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         bus_rdata <= '0;
      else
         bus_rdata <= next_rdata;
   end

endmodule

`default_nettype wire

/* cbl_unit_assertions.sv */
// Concurrent checks of the condition-bit, leading-zero and compare datapath
`default_nettype none
module cbl_unit_checker
   import cbl_pkg::*;
#(
   parameter logic [5:0] OPC_CMPLI = 6'h0A,
   parameter logic [9:0] XO_AND = 10'h101, XO_EQV = 10'h121, XO_NAND = 10'h0E1,
   parameter logic [9:0] XO_OR = 10'h1C1, XO_ORC = 10'h1A1, XO_XOR = 10'h0C1
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire cbl_issue_t        issue,
   input  wire logic [7:0]        bus_addr,
   input  wire logic [31:0]       bus_wdata,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   input  wire logic [31:0]       bus_rdata,
   input  wire cbl_gpr_wr_t       gpr_wr,
   input  wire logic [31:0]       cond_reg,
   input  wire logic              claimed,
   input  wire logic              invalid_form
);
   logic        en;
   logic [5:0]  op;
   logic [9:0]  xo;
   logic [4:0]  fmsb;
   logic        x, y, res, take, is_clz, is_cmp, is_bit, recog;
   logic [2:0]  rel;
   logic [5:0]  cnt;
   logic [31:0] bit_exp;

   // Shadow of the enable bit
   always_ff @(posedge clk or posedge rst)
      if (rst)
         en <= 1'b1;
      else if (bus_wr && bus_addr == CBL_OFS_CTRL)
         en <= bus_wdata[0];

   // Decode of the issued word
   assign op     = issue.word[31:26];
   assign xo     = issue.word[10:1];
   assign fmsb   = ~{issue.word[25:23], 2'b00};
   assign x      = cond_reg[~issue.word[20:16]];
   assign y      = cond_reg[~issue.word[15:11]];
   assign take   = issue.valid && en;
   assign is_clz = op == CBL_OPC_X31 && xo == CBL_XO_CLZ;
   assign is_cmp = op == OPC_CMPLI;
   assign is_bit = op == CBL_OPC_X19 && xo inside {XO_AND, CBL_XO_ANDC, XO_EQV, XO_NAND, CBL_XO_NOR, XO_OR, XO_ORC, XO_XOR};
   assign recog  = take && (is_clz || is_bit || (is_cmp && !issue.word[CBL_LEN_POS]));

   // Expected count, compare code and bit result
   always_comb
   begin
      cnt = 6'h20;
      for (int i = 0; i < 32; i++)
         if (issue.operand[i])
            cnt = 6'(31 - i);
      rel = issue.operand < {16'h0000, issue.word[15:0]} ? CBL_CMP_LESS :
            issue.operand > {16'h0000, issue.word[15:0]} ? CBL_CMP_GREAT : CBL_CMP_EQUAL;
      case (xo)
         XO_AND:      res = x & y;
         CBL_XO_ANDC: res = x & ~y;
         XO_EQV:      res = ~(x ^ y);
         XO_NAND:     res = ~(x & y);
         CBL_XO_NOR:  res = ~(x | y);
         XO_OR:       res = x | y;
         XO_ORC:      res = x | ~y;
         default:     res = x ^ y;
      endcase
      bit_exp = cond_reg;
      bit_exp[~issue.word[25:21]] = res;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_clz;
      take && is_clz;
   endsequence

   // ************
   // Assertions
   // ************
   chk_clz_count: assert property (s_clz |=> gpr_wr.wr_en && gpr_wr.data == {26'h0, $past(cnt)})
      else $error("leading zero count wrong");
   chk_clz_dest: assert property (s_clz |=> gpr_wr.idx == $past(issue.word[20:16]))
      else $error("count destination wrong");
   chk_clz_field: assert property (s_clz ##0 (issue.word[0] && !bus_wr) |=> !cond_reg[31]
      && cond_reg[30:28] == {!$past(issue.operand[31]), $past(issue.operand[31]), $past(issue.sum_ovf)}
      && cond_reg[27:0] == $past(cond_reg[27:0]))
      else $error("recorded count field wrong");
   chk_cmp_refused: assert property (take && is_cmp && issue.word[21] && !bus_wr |=> invalid_form && $stable(cond_reg))
      else $error("invalid compare form not refused");
   chk_cmp_field: assert property (take && is_cmp && !issue.word[21] && !bus_wr
      |=> cond_reg[$past(fmsb) -: 4] == {$past(rel), $past(issue.sum_ovf)})
      else $error("compare field wrong");
   chk_bit_logic: assert property (take && is_bit && !bus_wr |=> cond_reg == $past(bit_exp))
      else $error("condition bit result wrong");
   chk_claim_set: assert property (recog |=> claimed)
      else $error("executed instruction not claimed");
   chk_claim_idle: assert property (!recog |=> !claimed)
      else $error("claim without instruction");
   chk_wr_idle: assert property (!(take && is_clz) |=> !gpr_wr.wr_en)
      else $error("register write without count");
   chk_rdata_idle: assert property (!bus_rd |=> bus_rdata == 32'h0000_0000)
      else $error("read data outside read cycle");
   chk_read_cr: assert property (bus_rd && bus_addr == CBL_OFS_CR |=> bus_rdata == $past(cond_reg))
      else $error("condition register read wrong");
endmodule

bind cbl_unit cbl_unit_checker #(.OPC_CMPLI(OPC_CMPLI), .XO_AND(XO_AND), .XO_EQV(XO_EQV), .XO_NAND(XO_NAND),
   .XO_OR(XO_OR), .XO_ORC(XO_ORC), .XO_XOR(XO_XOR)) i_cbl_unit_checker (.clk(clk), .rst(rst), .issue(issue),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
   .gpr_wr(gpr_wr), .cond_reg(cond_reg), .claimed(claimed), .invalid_form(invalid_form));
`default_nettype wire

/* testbench.sv */
// Self-checking bench of the condition-bit, leading-zero and compare datapath
`default_nettype none
module testbench
   import cbl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   cbl_issue_t  issue = '0;
   logic [7:0]  bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic [31:0] bus_rdata, cond_reg;
   cbl_gpr_wr_t gpr_wr;
   logic        claimed, invalid_form;
   int          fail_count = 0;
   int          tests_run = 0;
   int          n_exec = 0;
   logic [31:0] exp_cr = 32'h0;
   logic [31:0] exp_cnt = 32'h0;
   logic        en = 1'b1;
   logic        exp_claim, exp_inv, exp_wr;
   logic [4:0]  exp_idx;
   logic [9:0]  xos [8] = '{10'h101, 10'h081, 10'h121, 10'h0E1, 10'h021, 10'h1C1, 10'h1A1, 10'h0C1};
   logic [31:0] zc [6] = '{32'h0, 32'h1, 32'h8000_0000, 32'h0001_0000, 32'h7FFF_FFFF, 32'h0000_8000};
   logic [31:0] co [4] = '{32'h0000_1233, 32'h0000_1234, 32'h0001_0000, 32'hFFFF_FFFF};

   // 50 MHz clock
   always #10 clk = ~clk;

   cbl_unit i_cbl_unit (.clk(clk), .rst(rst), .issue(issue), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .gpr_wr(gpr_wr), .cond_reg(cond_reg),
      .claimed(claimed), .invalid_form(invalid_form));

   // ************
   // Reference
   // ************
   function automatic logic [31:0] clz(input logic [31:0] v);
      clz = 32'h20;
      for (int i = 0; i < 32; i++)
         if (v[i])
            clz = 32'(31 - i);
   endfunction

   function automatic logic bitop(input int k, input logic x, input logic y);
      case (k)
         0: bitop = x & y;
         1: bitop = x & ~y;
         2: bitop = ~(x ^ y);
         3: bitop = ~(x & y);
         4: bitop = ~(x | y);
         5: bitop = x | y;
         6: bitop = x | ~y;
         default: bitop = x ^ y;
      endcase
   endfunction

   // Predicted effect of one issued word
   task automatic model(input logic [31:0] w, input logic [31:0] opd, input logic s);
      exp_claim = 1'b0;
      exp_inv = 1'b0;
      exp_wr = 1'b0;
      if (!en)
         return;
      if (w[31:26] == 6'h1F && w[10:1] == 10'h01A)
      begin
         exp_cnt = clz(opd);
         exp_wr = 1'b1;
         exp_idx = w[20:16];
         exp_claim = 1'b1;
         if (w[0])
            exp_cr[31:28] = {1'b0, exp_cnt != 0, exp_cnt == 0, s};
      end
      else if (w[31:26] == 6'h0A && w[21])
         exp_inv = 1'b1;
      else if (w[31:26] == 6'h0A)
      begin
         exp_cr[~{w[25:23], 2'b00} -: 4] = {(opd < {16'h0, w[15:0]} ? 3'h4 : opd > {16'h0, w[15:0]} ? 3'h2 : 3'h1), s};
         exp_claim = 1'b1;
      end
      else if (w[31:26] == 6'h13)
         for (int k = 0; k < 8; k++)
            if (w[10:1] == xos[k])
            begin
               exp_cr[~w[25:21]] = bitop(k, exp_cr[~w[20:16]], exp_cr[~w[15:11]]);
               exp_claim = 1'b1;
            end
      // Executed instructions seen by the counter register
      if (exp_claim)
         n_exec++;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   // One instruction, then its results
   task automatic run(input logic [31:0] w, input logic [31:0] opd, input logic s);
      @(posedge clk);
      issue <= '{1'b1, w, opd, s};
      model(w, opd, s);
      @(posedge clk);
      issue.valid <= 1'b0;
      #1;
      chk("cond_reg", exp_cr, cond_reg);
      chk("invalid_form", {31'h0, exp_inv}, {31'h0, invalid_form});
      chk("claimed", {31'h0, exp_claim}, {31'h0, claimed});
      chk("gpr_wr.wr_en", {31'h0, exp_wr}, {31'h0, gpr_wr.wr_en});
      if (exp_wr)
      begin
         chk("gpr_wr.idx", {27'h0, exp_idx}, {27'h0, gpr_wr.idx});
         chk("gpr_wr.data", exp_cnt, gpr_wr.data);
      end
   endtask

   task automatic bwr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      if (a == CBL_OFS_CTRL)
         en = d[0];
      if (a == CBL_OFS_CR)
         exp_cr = d;
   endtask

   task automatic brd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      chk("bus_rdata", e, bus_rdata);
   endtask

   task automatic conclude;
      if (fail_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ************
   // Scenarios
   // ************
   initial
   begin
      logic [31:0] r, v;
      void'($urandom(32'h5b62));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      brd(CBL_OFS_CR, 32'h0);
      for (int i = 0; i < 6; i++)
         run({6'h1F, 5'h03, 5'(i + 4), 5'h00, 10'h01A, i[0]}, zc[i], i[1]);
      brd(CBL_OFS_RESULT, exp_cnt);
      // Every bit operation, with shared and repeated indices
      for (int i = 0; i < 64; i++)
      begin
         bwr(CBL_OFS_CR, $urandom);
         r = $urandom;
         if (i % 4 == 0)
            r[20:11] = {r[25:21], r[25:21]};
         if (i % 4 == 1)
            r[15:11] = r[20:16];
         run({6'h13, r[25:11], xos[(i / 4) % 8], 1'b0}, 32'h0, 1'b0);
      end
      // Compare boundaries and the refused long form
      for (int i = 0; i < 4; i++)
         run({6'h0A, 3'(i * 2), 2'b00, 5'h02, 16'h1234}, co[i], i[0]);
      run({6'h0A, 3'h5, 2'b01, 5'h02, 16'h0000}, 32'h0, 1'b1);
      brd(CBL_OFS_STATUS, 32'h1);
      bwr(CBL_OFS_CTRL, 32'h0);
      run({6'h13, 15'h0000, 10'h121, 1'b0}, 32'h0, 1'b0);
      bwr(CBL_OFS_CTRL, 32'h1);
      brd(8'hFC, 32'h0);
      // Random mix of every kind and unknown words
      for (int i = 0; i < 300; i++)
      begin
         r = $urandom;
         v = $urandom;
         case (i % 4)
            0: {r[31:26], r[10:1]} = {6'h13, xos[v[2:0]]};
            1: {r[31:26], r[21]} = {6'h0A, r[21] & r[22]};
            2: {r[31:26], r[10:1], v} = {6'h1F, 10'h01A, v >> r[4:0]};
            default: ;
         endcase
         run(r, v, r[5]);
      end
      // Counter read-back, sticky clear and status read-back
      brd(CBL_OFS_COUNT, 32'(n_exec));
      bwr(CBL_OFS_STATUS, 32'h1);
      brd(CBL_OFS_STATUS, 32'h0);
      // Mid-run reset returns the condition register and enable bit to their idle values
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      exp_cr = 32'h0;
      en = 1'b1;
      #1;
      chk("cond_reg", exp_cr, cond_reg);
      brd(CBL_OFS_CTRL, 32'h1);
      run({6'h13, 15'h0000, 10'h121, 1'b0}, 32'h0, 1'b0);
      conclude;
   end

   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude;
   end
endmodule
`default_nettype wire
